// ### shared/cfg_io_consts.svh
/*
 * Parameter addresses, function selection codes, reset values and timing for the
 * configurable drive pin block.
 * Assumes a 16-bit parameter word port and four configurable pins.
 */
`ifndef CFG_IO_CONSTS_SVH
`define CFG_IO_CONSTS_SVH

// Parameter addresses
`define CDIO_ADDR_DIRECT_OUT 16'h0822
`define CDIO_ADDR_READBACK 16'h082a
`define CDIO_ADDR_FUNC_BASE 16'h0722
`define CDIO_ADDR_FUNC_STEP 16'h0002

// Input function codes
`define CDIO_IN_FREE 16'h0001
`define CDIO_IN_FAULT_RESET 16'h0002
`define CDIO_IN_ENABLE 16'h0003
`define CDIO_IN_HALT 16'h0004
`define CDIO_IN_JOG_POS 16'h0009
`define CDIO_IN_JOG_NEG 16'h000a
`define CDIO_IN_JOG_FAST 16'h000b
`define CDIO_IN_REF_SWITCH 16'h0014
`define CDIO_IN_UPPER_STOP 16'h0015
`define CDIO_IN_LOWER_STOP 16'h0016

// Output function codes
`define CDIO_OUT_FREE 16'h0065
`define CDIO_OUT_NO_FAULT 16'h0066
`define CDIO_OUT_ACTIVE 16'h0067

// Pins allowed to carry the end stop functions
`define CDIO_UPPER_STOP_PIN 0
`define CDIO_LOWER_STOP_PIN 1

// Reset values
`define CDIO_RST_DIRECT_OUT 16'h0000
`define CDIO_RST_FUNC_PIN0 16'h0015
`define CDIO_RST_FUNC_PIN1 16'h0016
`define CDIO_RST_FUNC_PIN2 16'h0001
`define CDIO_RST_FUNC_PIN3 16'h0014

// Synchroniser depth
`define CDIO_SYNC_STAGES 2

`endif

// ### shared/cfg_io_pkg.sv
/*
 * Types for the configurable drive pin block.
 * Assumes the constants header is included by the design files that need numbers.
 */
package cfg_io_pkg;

    typedef enum logic [3:0] {
        ROLE_IN_FREE,
        ROLE_FAULT_RESET,
        ROLE_ENABLE,
        ROLE_HALT,
        ROLE_JOG_POS,
        ROLE_JOG_NEG,
        ROLE_JOG_FAST,
        ROLE_REF_SWITCH,
        ROLE_UPPER_STOP,
        ROLE_LOWER_STOP,
        ROLE_OUT_FREE,
        ROLE_OUT_NO_FAULT,
        ROLE_OUT_ACTIVE
    } pin_role_t;

    typedef struct packed {
        logic faultReset;
        logic enable;
        logic halt;
        logic jogPos;
        logic jogNeg;
        logic jogFast;
        logic refSwitch;
        logic upperEndStop;
        logic lowerEndStop;
    } drive_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wrData;
        logic wr;
        logic rd;
    } param_req_t;

    typedef struct packed {
        logic [15:0] rdData;
        logic rdValid;
        logic err;
    } param_rsp_t;

endpackage

// ### verilog/pin_sync.sv
/*
 * Multi-bit two-flip-flop synchroniser for pin levels.
 * Assumes each bit is an independent level; no word coherence is implied.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule // pin_sync

`default_nettype wire

// ### verilog/configurable_drive_io_functions.sv
/*
 * Function logic behind the configurable pins of a drive: per-pin function
 * selection, input requests toward the drive core, output indications and
 * the parameter words for direct output and level readback.
 * Assumes pins are resolved outside from pinOut/pinOe, and that the drive
 * core signals are synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "cfg_io_consts.svh"

module configurable_drive_io_functions
    import cfg_io_pkg::*;
#(
    parameter int PINS = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe,
    input wire param_req_t paramReq,
    output param_rsp_t paramRsp,
    input wire logic faultPresent,
    input wire logic operationEnabled,
    output drive_req_t driveReq
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Map a selection code to a role; unknown codes fall back to a free input
    function automatic pin_role_t roleOf(input logic [15:0] code);
        pin_role_t role;
        role = ROLE_IN_FREE;
        unique case (code)
            `CDIO_IN_FAULT_RESET: role = ROLE_FAULT_RESET;
            `CDIO_IN_ENABLE: role = ROLE_ENABLE;
            `CDIO_IN_HALT: role = ROLE_HALT;
            `CDIO_IN_JOG_POS: role = ROLE_JOG_POS;
            `CDIO_IN_JOG_NEG: role = ROLE_JOG_NEG;
            `CDIO_IN_JOG_FAST: role = ROLE_JOG_FAST;
            `CDIO_IN_REF_SWITCH: role = ROLE_REF_SWITCH;
            `CDIO_IN_UPPER_STOP: role = ROLE_UPPER_STOP;
            `CDIO_IN_LOWER_STOP: role = ROLE_LOWER_STOP;
            `CDIO_OUT_FREE: role = ROLE_OUT_FREE;
            `CDIO_OUT_NO_FAULT: role = ROLE_OUT_NO_FAULT;
            `CDIO_OUT_ACTIVE: role = ROLE_OUT_ACTIVE;
            default: role = ROLE_IN_FREE;
        endcase
        return role;
    endfunction

    function automatic logic isOutputRole(input pin_role_t role);
        return (role == ROLE_OUT_FREE) || (role == ROLE_OUT_NO_FAULT)
            || (role == ROLE_OUT_ACTIVE);
    endfunction

    // End stop functions exist only on their dedicated pins
    function automatic logic codeAllowed(input int idx, input logic [15:0] code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            `CDIO_IN_FREE, `CDIO_IN_FAULT_RESET, `CDIO_IN_ENABLE, `CDIO_IN_HALT,
            `CDIO_IN_JOG_POS, `CDIO_IN_JOG_NEG, `CDIO_IN_JOG_FAST,
            `CDIO_IN_REF_SWITCH, `CDIO_OUT_FREE, `CDIO_OUT_NO_FAULT,
            `CDIO_OUT_ACTIVE: ok = 1'b1;
            `CDIO_IN_UPPER_STOP: ok = (idx == `CDIO_UPPER_STOP_PIN);
            `CDIO_IN_LOWER_STOP: ok = (idx == `CDIO_LOWER_STOP_PIN);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic [15:0] funcAddr(input int idx);
        logic [15:0] offs;
        offs = 16'(idx) * `CDIO_ADDR_FUNC_STEP;
        return 16'(`CDIO_ADDR_FUNC_BASE + offs);
    endfunction

    // One decode per address class, shared by the write, read and error paths
    function automatic logic isDirectAddr(input logic [15:0] addr);
        return addr == `CDIO_ADDR_DIRECT_OUT;
    endfunction

    function automatic logic isReadbackAddr(input logic [15:0] addr);
        return addr == `CDIO_ADDR_READBACK;
    endfunction

    function automatic logic isFuncAddr(input logic [15:0] addr, input int idx);
        return addr == funcAddr(idx);
    endfunction

    function automatic logic [15:0] funcReset(input int idx);
        logic [15:0] val;
        val = `CDIO_IN_FREE;
        unique case (idx)
            0: val = `CDIO_RST_FUNC_PIN0;
            1: val = `CDIO_RST_FUNC_PIN1;
            2: val = `CDIO_RST_FUNC_PIN2;
            3: val = `CDIO_RST_FUNC_PIN3;
            default: val = `CDIO_IN_FREE;
        endcase
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage and synchronised pin levels

    logic [15:0] funcSel [PINS];
    logic [15:0] directOut;
    logic [PINS-1:0] pinLevel;
    logic faultResetPrev;
    pin_role_t role [PINS];
    logic [PINS-1:0] funcHit;
    logic addrKnown;
    logic wrReject;
    logic [15:0] next_rdData;
    drive_req_t next_driveReq;
    logic faultResetLevel;

    pin_sync #(
        .WIDTH(PINS)
    ) i_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn(pinIn),
        .syncOut(pinLevel)
    );

    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            role[i] = roleOf(funcSel[i]);
            funcHit[i] = isFuncAddr(paramReq.addr, i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parameter writes

    always_comb
    begin
        addrKnown = isDirectAddr(paramReq.addr) || isReadbackAddr(paramReq.addr)
            || (|funcHit);
        wrReject = !addrKnown || isReadbackAddr(paramReq.addr);
        for (int i = 0; i < PINS; i++)
        begin
            if (funcHit[i] && !codeAllowed(i, paramReq.wrData))
            begin
                wrReject = 1'b1;
            end
        end
    end

    // The full word is kept even where a pin does not qualify
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            directOut <= `CDIO_RST_DIRECT_OUT;
        end
        else if (paramReq.wr && isDirectAddr(paramReq.addr))
        begin
            directOut <= paramReq.wrData;
        end
    end

    // An illegal code is refused and the old function stays in force
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < PINS; i++)
            begin
                funcSel[i] <= funcReset(i);
            end
        end
        else if (paramReq.wr && !wrReject)
        begin
            for (int i = 0; i < PINS; i++)
            begin
                if (funcHit[i])
                begin
                    funcSel[i] <= paramReq.wrData;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parameter reads and error answer

    always_comb
    begin
        next_rdData = 16'h0000;
        if (isDirectAddr(paramReq.addr))
        begin
            next_rdData = directOut;
        end
        else if (isReadbackAddr(paramReq.addr))
        begin
            next_rdData[PINS-1:0] = pinLevel;
        end
        for (int i = 0; i < PINS; i++)
        begin
            if (funcHit[i])
            begin
                next_rdData = funcSel[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            paramRsp <= '0;
        end
        else
        begin
            paramRsp.rdValid <= paramReq.rd;
            paramRsp.rdData <= paramReq.rd ? next_rdData : 16'h0000;
            paramRsp.err <= (paramReq.rd && !addrKnown) || (paramReq.wr && wrReject);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins

    // Enable depends on the function only, never on the direct word
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOe <= '0;
        end
        else
        begin
            for (int i = 0; i < PINS; i++)
            begin
                pinOe[i] <= isOutputRole(role[i]);
            end
        end
    end

    // Direct bits only reach pins whose function is free output
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOut <= '0;
        end
        else
        begin
            for (int i = 0; i < PINS; i++)
            begin
                unique case (role[i])
                    ROLE_OUT_FREE: pinOut[i] <= directOut[i];
                    ROLE_OUT_NO_FAULT: pinOut[i] <= !faultPresent;
                    ROLE_OUT_ACTIVE: pinOut[i] <= operationEnabled;
                    default: pinOut[i] <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input requests toward the drive core

    // Fault reset pins are gathered apart, since only their rising edge is passed on
    always_comb
    begin
        faultResetLevel = 1'b0;
        for (int i = 0; i < PINS; i++)
        begin
            if (role[i] == ROLE_FAULT_RESET)
            begin
                faultResetLevel = faultResetLevel | pinLevel[i];
            end
        end
    end

    // Several pins on one function are ORed; a free input adds nothing
    always_comb
    begin
        next_driveReq = '0;
        for (int i = 0; i < PINS; i++)
        begin
            unique case (role[i])
                ROLE_ENABLE: next_driveReq.enable |= pinLevel[i];
                ROLE_HALT: next_driveReq.halt |= pinLevel[i];
                ROLE_JOG_POS: next_driveReq.jogPos |= pinLevel[i];
                ROLE_JOG_NEG: next_driveReq.jogNeg |= pinLevel[i];
                ROLE_JOG_FAST: next_driveReq.jogFast |= pinLevel[i];
                ROLE_REF_SWITCH: next_driveReq.refSwitch |= pinLevel[i];
                ROLE_UPPER_STOP: next_driveReq.upperEndStop |= pinLevel[i];
                ROLE_LOWER_STOP: next_driveReq.lowerEndStop |= pinLevel[i];
                default: next_driveReq.faultReset |= 1'b0;
            endcase
        end
        // Edge only, so a held button does not keep clearing new errors
        next_driveReq.faultReset = faultResetLevel && !faultResetPrev;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            faultResetPrev <= 1'b0;
        end
        else
        begin
            faultResetPrev <= faultResetLevel;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            driveReq <= '0;
        end
        else
        begin
            driveReq <= next_driveReq;
        end
    end

endmodule // configurable_drive_io_functions

`default_nettype wire

// ### tb/cfg_io_props.sv
/* Checker for the configurable pin block, bound to its top module.
   Assumes one clock domain; shadows only writes that were not refused. */
`timescale 1ns/1ps
`default_nettype none

module cfg_io_props
    import cfg_io_pkg::*;
#(
    parameter int PINS = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [PINS-1:0] pinIn,
    input wire logic [PINS-1:0] pinOut,
    input wire logic [PINS-1:0] pinOe,
    input wire param_req_t paramReq,
    input wire param_rsp_t paramRsp,
    input wire logic faultPresent,
    input wire logic operationEnabled,
    input wire drive_req_t driveReq
);
    // Shadow commits one edge late, which lines it up with the registered pins
    logic [15:0] fnS [PINS];
    logic [15:0] dOut, pAddr, pData;
    logic pWr;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pWr <= 1'b0;
            pAddr <= 16'h0000;
            pData <= 16'h0000;
            dOut <= 16'h0000;
        end
        else
        begin
            pWr <= paramReq.wr;
            pAddr <= paramReq.addr;
            pData <= paramReq.wrData;
            if (paramReq.wr && paramReq.addr == 16'h0822)
                dOut <= paramReq.wrData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            fnS <= '{16'h0015, 16'h0016, 16'h0001, 16'h0014};
        else if (pWr && !paramRsp.err && pAddr >= 16'h0722 && pAddr <= 16'h0728)
            fnS[2'(pAddr[3:1] - 3'h1)] <= pData;
    end

    ////////////////////////////////////////
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence quietPins;
        $stable(pinIn) [*4];
    endsequence

    for (genvar i = 0; i < PINS; i++)
    begin : g_pin
        a_free_output: assert property (fnS[i] == 16'h0065 |->
            pinOe[i] && pinOut[i] == $past(dOut[i]))
            else $error("free output off its bit");
        a_fault_output: assert property (fnS[i] == 16'h0066 |->
            pinOe[i] && pinOut[i] == !$past(faultPresent))
            else $error("no fault output wrong");
        a_active_output: assert property (fnS[i] == 16'h0067 |->
            pinOe[i] && pinOut[i] == $past(operationEnabled))
            else $error("active output wrong");
        a_input_no_drive: assert property (fnS[i] < 16'h0065 |-> !pinOe[i])
            else $error("input pin driven");
    end

    a_direct_read: assert property (paramReq.rd && paramReq.addr == 16'h0822 |=>
        paramRsp.rdValid && !paramRsp.err && paramRsp.rdData == $past(dOut))
        else $error("direct word read wrong");
    a_readback_ro: assert property (paramReq.wr && paramReq.addr == 16'h082a |=>
        paramRsp.err)
        else $error("readback write accepted");
    a_readback_level: assert property (quietPins ##0
        (paramReq.rd && paramReq.addr == 16'h082a) |=>
        paramRsp.rdValid && paramRsp.rdData == 16'($past(pinIn)))
        else $error("readback level wrong");
    a_reset_pulse: assert property (driveReq.faultReset |=> !driveReq.faultReset)
        else $error("fault reset not a pulse");
    a_quiet_port: assert property (!(paramReq.rd || paramReq.wr) |=>
        !paramRsp.rdValid && !paramRsp.err)
        else $error("answer without request");
endmodule // cfg_io_props

bind configurable_drive_io_functions cfg_io_props #(.PINS(PINS)) i_cfg_io_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .paramReq(paramReq), .paramRsp(paramRsp), .faultPresent(faultPresent),
    .operationEnabled(operationEnabled), .driveReq(driveReq));
`default_nettype wire

// ### tb/switch_model.sv
/* Switches and control lines on the four pins.
   Assumes a driving pin wins over its switch. */
`timescale 1ns/1ps
`default_nettype none

module switch_model (
    input wire logic [3:0] sw,
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe,
    output logic [3:0] pinIn
);
    // Wire level resolved from the block's enable, else the switch
    assign pinIn = (pinOe & pinOut) | (~pinOe & sw);
endmodule // switch_model
`default_nettype wire

// ### tb/test_configurable_drive_io_functions.sv
/* Self-checking bench for the configurable pin block.
   Assumes the switch model on the pins and the checker bound in. */
`timescale 1ns/1ps
`default_nettype none

module test_configurable_drive_io_functions
    import cfg_io_pkg::*;
;
    logic sys_clk, rst_n, fault, opEn;
    logic [3:0] sw, pinIn, pinOut, pinOe;
    param_req_t req;
    param_rsp_t rsp;
    drive_req_t driveReq;
    logic [15:0] fnv [4];
    logic [15:0] dw;
    logic [15:0] ic [8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0009, 16'h000a,
        16'h000b, 16'h0014};
    int failures, checks_done, n;

    configurable_drive_io_functions #(.PINS(4)) i_configurable_drive_io_functions (
        .sys_clk(sys_clk), .rst_n(rst_n), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .paramReq(req), .paramRsp(rsp), .faultPresent(fault), .operationEnabled(opEn),
        .driveReq(driveReq));
    switch_model i_switch_model (.sw(sw), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] a, d, exp, input logic eErr);
        @(posedge sys_clk);
        req <= '{addr: a, wrData: d, wr: w, rd: !w};
        @(posedge sys_clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1;
        chk("err", {15'h0000, eErr}, {15'h0000, rsp.err});
        chk("rdValid", {15'h0000, !w}, {15'h0000, rsp.rdValid});
        if (!w)
            chk("rdData", exp, rsp.rdData);
    endtask

    task automatic set_fn(input int p, input logic [15:0] c);
        acc(1'b1, 16'h0722 + 16'(2 * p), c, 16'h0000, 1'b0);
        fnv[p] = c;
    endtask

    // Request bits that one input pin adds, from its function code and level
    function automatic drive_req_t exp_req(input logic [15:0] code, input logic lvl);
        drive_req_t r;
        r = '0;
        case (code)
            16'h0003: r.enable = lvl;
            16'h0004: r.halt = lvl;
            16'h0009: r.jogPos = lvl;
            16'h000a: r.jogNeg = lvl;
            16'h000b: r.jogFast = lvl;
            16'h0014: r.refSwitch = lvl;
            16'h0015: r.upperEndStop = lvl;
            16'h0016: r.lowerEndStop = lvl;
            default: r = '0;
        endcase
        return r;
    endfunction

    // Expectations are worked out after the wait, once the new inputs have landed
    task automatic check_pins();
        logic [3:0] ee, eo, lv;
        drive_req_t er;
        repeat (4) @(posedge sys_clk);
        #1;
        er = '0;
        for (int i = 0; i < 4; i++)
        begin
            ee[i] = fnv[i] > 16'h0064;
            eo[i] = fnv[i] == 16'h0065 ? dw[i] : fnv[i] == 16'h0066 ? !fault : opEn;
            lv[i] = ee[i] ? eo[i] : sw[i];
            if (!ee[i])
                er = er | exp_req(fnv[i], lv[i]);
        end
        chk("pinOe", {12'h000, ee}, {12'h000, pinOe});
        chk("pinOut", {12'h000, eo & ee}, {12'h000, pinOut & pinOe});
        chk("driveReq", {7'h00, er}, {7'h00, driveReq});
        acc(1'b0, 16'h082a, 16'h0000, {12'h000, lv}, 1'b0);
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////
    initial
    begin
        repeat (8000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        req = '0;
        sw = 4'h0;
        fault = 1'b0;
        opEn = 1'b0;
        dw = 16'h0000;
        fnv = '{16'h0015, 16'h0016, 16'h0001, 16'h0014};
        void'($urandom(32'h95ae));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
            acc(1'b0, 16'h0722 + 16'(2 * i), 16'h0000, fnv[i], 1'b0);
        acc(1'b0, 16'h0822, 16'h0000, 16'h0000, 1'b0);
        acc(1'b0, 16'h0900, 16'h0000, 16'h0000, 1'b1);
        acc(1'b1, 16'h082a, 16'h0005, 16'h0000, 1'b1);
        acc(1'b1, 16'h0726, 16'h0015, 16'h0000, 1'b1);
        acc(1'b1, 16'h0722, 16'h0016, 16'h0000, 1'b1);
        acc(1'b1, 16'h0728, 16'h0005, 16'h0000, 1'b1);
        @(posedge sys_clk);
        sw <= 4'hb;
        check_pins();
        foreach (ic[k])
        begin
            @(posedge sys_clk);
            sw <= 4'h0;
            set_fn(2, ic[k]);
            @(posedge sys_clk);
            sw <= 4'h4;
            n = 0;
            repeat (6)
            begin
                @(posedge sys_clk);
                #1;
                n += int'(driveReq.faultReset);
            end
            chk("pulses", 16'(n), {15'h0000, ic[k] == 16'h0002});
            check_pins();
        end
        repeat (30)
        begin
            set_fn($urandom_range(3), 16'h0065 + 16'($urandom_range(2)));
            dw = 16'($urandom);
            acc(1'b1, 16'h0822, dw, 16'h0000, 1'b0);
            acc(1'b0, 16'h0822, 16'h0000, dw, 1'b0);
            @(posedge sys_clk);
            {fault, opEn, sw} <= 6'($urandom);
            check_pins();
        end
        give_verdict();
    end
endmodule // test_configurable_drive_io_functions
`default_nettype wire
